// ==== vfr_ctrl.sv ====
// Output overvoltage and undervoltage fault response control.
// Assumes a bus transport that decodes commands into one-cycle strobes,
// a soft-start engine that reports the end of each rise time, and
// status registers that take one-cycle set events.
//
// Contract
// - Ignore mode keeps regulating, still sets flags
// - Ignore mode still raises alert unless masked
// - Enable bit one shuts down, follows retry
// - Retry 000 never restarts until cleared
// - Retry 111 restarts endlessly via soft start
// - Bad retry rejected, cml, ivd, alert
// - Store only retry bit 5, rebuild others
// - Delay 000 means no delay, retry 000
// - Delay 111 waits seven rise times
// - Delay bits mirror retry bit 5
// - Undervoltage sets oth, vout, uv, alert
// - Loop slave blocks access, ivc, alert
// - Store-all copies storable bits to memory
// - Undervoltage default shut down, delayed restart
// - Code 45h layout, bit 6 reads zero
// - Overvoltage sets ovf, vout, ov, alert
// - Overvoltage default matches undervoltage layout
`timescale 1ns/1ns
`include "vfr_consts.svh"

module vfr_ctrl (
    input  wire logic             clk_sys,        // System clock, 25 MHz
    input  wire logic             rst,            // Synchronous reset
    input  wire vfr_pkg::vfr_cmd_t cmd,           // Command access
    input  wire logic             loop_slave,     // Device is loop slave
    input  wire logic             ov_fault,       // Overvoltage detect
    input  wire logic             uv_fault,       // Undervoltage detect
    input  wire logic             fault_clear,    // Faults cleared
    input  wire logic             output_off,     // Commanded off
    input  wire logic             rise_done,      // Rise time elapsed
    input  wire logic             alert_masked,   // Alert source masked
    input  wire logic             nvm_load,       // Load from memory
    input  wire logic [1:0]       nvm_rd_bits,    // {ov,uv} stored bits
    input  wire logic [1:0]       nvm_rd_en,      // {ov,uv} enable bits
    output logic [7:0]            rd_data,        // Read data
    output logic                  cmd_nack,       // NACK the command
    output vfr_pkg::vfr_evt_t     status_evt,     // Status set pulses
    output logic                  smbalert_req,   // Alert request pulse
    output logic                  output_enable,  // Power stage enable
    output logic                  softstart_go,   // Start a soft start
    output logic                  nvm_wr,         // Store strobe
    output logic [3:0]            nvm_wr_data     // {ov en,ov rs,uv..}
);

    // ---------------------------------------------------------------
    // Stored settings
    // ---------------------------------------------------------------
    logic       ov_en_reg;     // Overvoltage shutdown select
    logic [2:0] ov_rs_reg;     // Overvoltage restart policy
    logic       uv_en_reg;     // Undervoltage shutdown select
    logic [2:0] uv_rs_reg;     // Undervoltage restart policy

    // Reset image of both response registers
    localparam logic [7:0] RESP_RESET = `VFR_RESP_RESET;
    localparam logic [2:0] RESET_RS   =
        RESP_RESET[`VFR_BIT_RETRY_HI:`VFR_BIT_RETRY_LO];

    // ---------------------------------------------------------------
    // Access decode
    // ---------------------------------------------------------------
    logic hit_ov;              // Overvoltage command addressed
    logic hit_uv;              // Undervoltage command addressed
    logic wr_ok;               // Write data has legal retry field
    logic [2:0] wr_rs;         // Retry field of the write data
    logic blocked;             // Loop slave access attempt

    assign hit_ov  = (cmd.code == `VFR_CMD_OV_RESP);
    assign hit_uv  = (cmd.code == `VFR_CMD_UV_RESP);
    assign blocked = loop_slave && (hit_ov || hit_uv)
                     && (cmd.wr || cmd.rd);
    assign wr_rs   = cmd.data[`VFR_BIT_RETRY_HI:`VFR_BIT_RETRY_LO];
    assign wr_ok   = (wr_rs == `VFR_RETRY_NONE)
                     || (wr_rs == `VFR_RETRY_ALWAYS);

    // Overvoltage setting register
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ov_en_reg <= RESP_RESET[`VFR_BIT_ENABLE];
            ov_rs_reg <= RESET_RS;
        end else if (nvm_load) begin
            ov_en_reg <= nvm_rd_en[1];
            ov_rs_reg <= {3{nvm_rd_bits[1]}};
        end else if (cmd.wr && hit_ov && !loop_slave && wr_ok) begin
            ov_en_reg <= cmd.data[`VFR_BIT_ENABLE];
            ov_rs_reg <= wr_rs;
        end
    end

    // Undervoltage setting register
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            uv_en_reg <= RESP_RESET[`VFR_BIT_ENABLE];
            uv_rs_reg <= RESET_RS;
        end else if (nvm_load) begin
            uv_en_reg <= nvm_rd_en[0];
            uv_rs_reg <= {3{nvm_rd_bits[0]}};
        end else if (cmd.wr && hit_uv && !loop_slave && wr_ok) begin
            uv_en_reg <= cmd.data[`VFR_BIT_ENABLE];
            uv_rs_reg <= wr_rs;
        end
    end

    // ---------------------------------------------------------------
    // Read path and access answers
    // ---------------------------------------------------------------
    // Read data; bit 6 zero, delay bits copy retry bit 5
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rd_data <= 8'h00;
        end else if (cmd.rd && !loop_slave && hit_ov) begin
            rd_data <= {ov_en_reg, 1'b0, ov_rs_reg,
                        {3{ov_rs_reg[2]}}};
        end else if (cmd.rd && !loop_slave && hit_uv) begin
            rd_data <= {uv_en_reg, 1'b0, uv_rs_reg,
                        {3{uv_rs_reg[2]}}};
        end
    end

    // NACK for blocked accesses
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cmd_nack <= 1'b0;
        end else begin
            cmd_nack <= blocked;
        end
    end

    // ---------------------------------------------------------------
    // Store to nonvolatile memory
    // ---------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            nvm_wr      <= 1'b0;
            nvm_wr_data <= 4'h0;
        end else begin
            nvm_wr      <= cmd.wr && (cmd.code == `VFR_CMD_STORE_ALL);
            nvm_wr_data <= {ov_en_reg, ov_rs_reg[2],
                            uv_en_reg, uv_rs_reg[2]};
        end
    end

    // ---------------------------------------------------------------
    // Fault edge detect and status events
    // ---------------------------------------------------------------
    logic ov_seen_reg;         // Last overvoltage level
    logic uv_seen_reg;         // Last undervoltage level
    logic ov_rise;             // New overvoltage fault
    logic uv_rise;             // New undervoltage fault
    logic bad_wr;              // Rejected write

    assign ov_rise = ov_fault && !ov_seen_reg;
    assign uv_rise = uv_fault && !uv_seen_reg;
    assign bad_wr  = cmd.wr && (hit_ov || hit_uv) && !loop_slave
                     && !wr_ok;

    // Fault level history
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ov_seen_reg <= 1'b0;
            uv_seen_reg <= 1'b0;
        end else begin
            ov_seen_reg <= ov_fault;
            uv_seen_reg <= uv_fault;
        end
    end

    // Status pulses, set in either response mode
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            status_evt   <= '0;
            smbalert_req <= 1'b0;
        end else begin
            status_evt.byte_ovf  <= ov_rise;
            status_evt.vout_ov   <= ov_rise;
            status_evt.byte_oth  <= uv_rise;
            status_evt.vout_uv   <= uv_rise;
            status_evt.word_vout <= ov_rise || uv_rise;
            status_evt.cml       <= bad_wr;
            status_evt.ivd       <= bad_wr;
            status_evt.invalid_command_fault       <= blocked;
            smbalert_req <= !alert_masked
                && (ov_rise || uv_rise || bad_wr || blocked);
        end
    end

    // ---------------------------------------------------------------
    // Shutdown and restart sequencers, one per fault
    // ---------------------------------------------------------------
    vfr_pkg::vfr_state_t ov_st_reg;   // Overvoltage sequencer
    vfr_pkg::vfr_state_t uv_st_reg;   // Undervoltage sequencer
    logic [3:0] ov_cnt_reg;           // Overvoltage rise-time count
    logic [3:0] uv_cnt_reg;           // Undervoltage rise-time count

    // Overvoltage sequencer
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ov_st_reg  <= vfr_pkg::VFR_RUN;
            ov_cnt_reg <= 4'h0;
        end else begin
            case (ov_st_reg)
                vfr_pkg::VFR_RUN: begin
                    // Ignore mode keeps running
                    if (ov_rise && ov_en_reg) begin
                        ov_cnt_reg <= 4'h0;
                        ov_st_reg  <= (ov_rs_reg == `VFR_RETRY_NONE)
                            ? vfr_pkg::VFR_LATCH
                            : vfr_pkg::VFR_WAIT;
                    end
                end
                vfr_pkg::VFR_WAIT: begin
                    // Commanded off drops the pending restart
                    if (output_off) begin
                        ov_st_reg <= vfr_pkg::VFR_LATCH;
                    end else if (rise_done) begin
                        // One more rise time of delay gone
                        ov_cnt_reg <= ov_cnt_reg + 4'h1;
                        if (ov_cnt_reg == `VFR_DELAY_RISES - 4'h1) begin
                            ov_st_reg <= vfr_pkg::VFR_START;
                        end
                    end
                end
                vfr_pkg::VFR_START: begin
                    // Soft start handed off, back to normal run
                    ov_st_reg <= vfr_pkg::VFR_RUN;
                end
                vfr_pkg::VFR_LATCH: begin
                    // Stay off until the faults are cleared
                    if (fault_clear) begin
                        ov_st_reg <= vfr_pkg::VFR_RUN;
                    end
                end
                default: ov_st_reg <= vfr_pkg::VFR_RUN;
            endcase
        end
    end

    // Undervoltage sequencer
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            uv_st_reg  <= vfr_pkg::VFR_RUN;
            uv_cnt_reg <= 4'h0;
        end else begin
            case (uv_st_reg)
                vfr_pkg::VFR_RUN: begin
                    // Ignore mode keeps running
                    if (uv_rise && uv_en_reg) begin
                        uv_cnt_reg <= 4'h0;
                        uv_st_reg  <= (uv_rs_reg == `VFR_RETRY_NONE)
                            ? vfr_pkg::VFR_LATCH
                            : vfr_pkg::VFR_WAIT;
                    end
                end
                vfr_pkg::VFR_WAIT: begin
                    // Commanded off drops the pending restart
                    if (output_off) begin
                        uv_st_reg <= vfr_pkg::VFR_LATCH;
                    end else if (rise_done) begin
                        // One more rise time of delay gone
                        uv_cnt_reg <= uv_cnt_reg + 4'h1;
                        if (uv_cnt_reg == `VFR_DELAY_RISES - 4'h1) begin
                            uv_st_reg <= vfr_pkg::VFR_START;
                        end
                    end
                end
                vfr_pkg::VFR_START: begin
                    // Soft start handed off, back to normal run
                    uv_st_reg <= vfr_pkg::VFR_RUN;
                end
                vfr_pkg::VFR_LATCH: begin
                    // Stay off until the faults are cleared
                    if (fault_clear) begin
                        uv_st_reg <= vfr_pkg::VFR_RUN;
                    end
                end
                default: uv_st_reg <= vfr_pkg::VFR_RUN;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // Power stage control
    // ---------------------------------------------------------------
    // Enabled only when both sequencers run
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            output_enable <= 1'b1;
            softstart_go  <= 1'b0;
        end else begin
            output_enable <= (ov_st_reg == vfr_pkg::VFR_RUN)
                && (uv_st_reg == vfr_pkg::VFR_RUN)
                && !(ov_rise && ov_en_reg)
                && !(uv_rise && uv_en_reg);
            softstart_go  <= (ov_st_reg == vfr_pkg::VFR_START)
                || (uv_st_reg == vfr_pkg::VFR_START);
        end
    end

endmodule

// ==== vfr_consts.svh ====
// Constants for the output voltage fault response block.
// Assumes inclusion by the package and the block; definitions only.
`ifndef VFR_CONSTS_SVH
`define VFR_CONSTS_SVH

// ---------------------------------------------------------------
// Command codes
// ---------------------------------------------------------------
`define VFR_CMD_OV_RESP     8'h41
`define VFR_CMD_UV_RESP     8'h45
`define VFR_CMD_STORE_ALL   8'h11

// ---------------------------------------------------------------
// Response register layout
// ---------------------------------------------------------------
`define VFR_RESP_RESET      8'hBF
`define VFR_BIT_ENABLE      7
`define VFR_BIT_RETRY_HI    5
`define VFR_BIT_RETRY_LO    3
`define VFR_RETRY_NONE      3'h0
`define VFR_RETRY_ALWAYS    3'h7
`define VFR_DELAY_RISES     4'h7

`endif

// ==== vfr_pkg.sv ====
// Types for the output voltage fault response block.
// Assumes vfr_consts.svh sits in the include path.
`include "vfr_consts.svh"

package vfr_pkg;

    // ---------------------------------------------------------------
    // Command access from the bus transport
    // ---------------------------------------------------------------
    typedef struct packed {
        logic       wr;     // Write strobe
        logic       rd;     // Read strobe
        logic [7:0] code;   // Command code
        logic [7:0] data;   // Write data
    } vfr_cmd_t;

    // Status events toward the status registers
    typedef struct packed {
        logic byte_ovf;     // Overvoltage flag in status byte
        logic byte_oth;     // Other-fault flag in status byte
        logic word_vout;    // Output-voltage summary in status word
        logic vout_ov;      // Overvoltage flag in status vout
        logic vout_uv;      // Undervoltage flag in status vout
        logic cml;          // Communication fault
        logic ivd;          // Invalid data
        logic invalid_command_fault;          // Invalid command
    } vfr_evt_t;

    // Per-fault sequencer states, one-hot
    typedef enum logic [3:0] {
        VFR_RUN   = 4'h1,
        VFR_WAIT  = 4'h2,
        VFR_START = 4'h4,
        VFR_LATCH = 4'h8
    } vfr_state_t;

endpackage

// ==== vfr_ctrl_chk.sv ====
// Checker: port-level properties of the fault response block.
// Assumes it is bound to every vfr_ctrl instance; one clock domain.
`timescale 1ns/1ns
`include "vfr_consts.svh"

module vfr_ctrl_chk (
    input wire logic              clk_sys,
    input wire logic              rst,
    input wire vfr_pkg::vfr_cmd_t cmd,
    input wire logic              loop_slave,
    input wire logic              ov_fault,
    input wire logic              uv_fault,
    input wire logic              rise_done,
    input wire logic              alert_masked,
    input wire logic [7:0]        rd_data,
    input wire logic              cmd_nack,
    input wire vfr_pkg::vfr_evt_t status_evt,
    input wire logic              smbalert_req,
    input wire logic              output_enable,
    input wire logic              softstart_go
);
    // -----------------------------------------------------------
    // Helper logic
    // -----------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    logic       resp_hit;      // Access to either response command
    logic [3:0] rise_cnt_reg;  // Rise times seen while output is off
    assign resp_hit = cmd.code == `VFR_CMD_OV_RESP
                   || cmd.code == `VFR_CMD_UV_RESP;

    // Count rise times only while shut down; saturate at 15
    always_ff @(posedge clk_sys) begin
        if (rst || output_enable) begin
            rise_cnt_reg <= 4'h0;
        end else if (rise_done && rise_cnt_reg != 4'hF) begin
            rise_cnt_reg <= rise_cnt_reg + 4'h1;
        end
    end

    // -----------------------------------------------------------
    // Properties
    // -----------------------------------------------------------
    a_uv_flags: assert property (
        $rose(uv_fault) && !$past(rst) |=> status_evt.vout_uv
        && status_evt.byte_oth && status_evt.word_vout)
        else $error("undervoltage flags missing");
    a_ov_flags: assert property (
        $rose(ov_fault) && !$past(rst) |=> status_evt.vout_ov
        && status_evt.byte_ovf && status_evt.word_vout)
        else $error("overvoltage flags missing");
    a_fault_alert: assert property (
        ($rose(ov_fault) || $rose(uv_fault)) && !alert_masked
        && !$past(rst) |=> smbalert_req)
        else $error("fault alert missing");
    a_bad_retry: assert property (
        cmd.wr && resp_hit && !loop_slave && !alert_masked
        && cmd.data[5:3] != 3'h0 && cmd.data[5:3] != 3'h7
        |=> status_evt.cml && status_evt.ivd && smbalert_req)
        else $error("bad retry not flagged");
    a_slave_block: assert property (
        (cmd.wr || cmd.rd) && resp_hit && loop_slave
        |=> cmd_nack && status_evt.invalid_command_fault)
        else $error("loop slave access not refused");
    a_read_image: assert property (
        cmd.rd && resp_hit && !loop_slave |=> !rd_data[6]
        && rd_data[2:0] == {3{rd_data[5]}}
        && (rd_data[5:3] == 3'h0 || rd_data[5:3] == 3'h7))
        else $error("read image malformed");
    a_delay_count: assert property (
        softstart_go |-> rise_cnt_reg >= 4'h7)
        else $error("restart before seven rise times");
    a_go_enable: assert property (
        softstart_go |-> ##[0:2] output_enable)
        else $error("restart did not enable output");
endmodule

bind vfr_ctrl vfr_ctrl_chk u_chk (.clk_sys(clk_sys), .rst(rst),
    .cmd(cmd), .loop_slave(loop_slave), .ov_fault(ov_fault),
    .uv_fault(uv_fault), .rise_done(rise_done),
    .alert_masked(alert_masked), .rd_data(rd_data),
    .cmd_nack(cmd_nack), .status_evt(status_evt),
    .smbalert_req(smbalert_req), .output_enable(output_enable),
    .softstart_go(softstart_go));

// ==== vfr_host_model.sv ====
// Host side model: single-byte command reads and writes.
// Assumes the bench calls xfer through the instance name.
`timescale 1ns/1ns

module vfr_host_model (
    input  wire logic        clk_sys,  // System clock
    output vfr_pkg::vfr_cmd_t cmd      // Command access
);
    // Idle bus: no strobes
    initial begin
        cmd = '0;
    end

    // One access: strobe held for one edge, then idle bus shows
    // inverted code and data so stale values never look valid
    task automatic xfer(input logic w, input logic [7:0] c,
                        input logic [7:0] d);
        @(posedge clk_sys);
        #1;
        cmd = '{wr: w, rd: !w, code: c, data: d};
        @(posedge clk_sys);
        #1;
        cmd = '{wr: 1'b0, rd: 1'b0, code: ~c, data: ~d};
    endtask
endmodule

// ==== vfr_ctrl_tb.sv ====
// Bench: directed sequences for the fault response block.
// Assumes the host model and checker files compile first.
`timescale 1ns/1ns
`include "vfr_consts.svh"

module vfr_ctrl_tb;
    logic              clk_sys, rst, loop_slave, ov_fault, uv_fault;
    logic              fault_clear, output_off, rise_done;
    logic              alert_masked, nvm_load;
    logic [1:0]        nvm_rd_bits, nvm_rd_en;
    vfr_pkg::vfr_cmd_t cmd;
    vfr_pkg::vfr_evt_t status_evt;
    logic [7:0]        rd_data;
    logic              cmd_nack, smbalert_req, output_enable;
    logic              softstart_go, nvm_wr;
    logic [3:0]        nvm_wr_data;
    int                fails, n_checks, cycles;
    localparam logic [7:0] OV = `VFR_CMD_OV_RESP;  // Overvoltage code
    localparam logic [7:0] UV = `VFR_CMD_UV_RESP;  // Undervoltage code

    vfr_host_model host (.clk_sys(clk_sys), .cmd(cmd));
    vfr_ctrl dut (.clk_sys(clk_sys), .rst(rst), .cmd(cmd),
        .loop_slave(loop_slave), .ov_fault(ov_fault),
        .uv_fault(uv_fault), .fault_clear(fault_clear),
        .output_off(output_off), .rise_done(rise_done),
        .alert_masked(alert_masked), .nvm_load(nvm_load),
        .nvm_rd_bits(nvm_rd_bits), .nvm_rd_en(nvm_rd_en),
        .rd_data(rd_data), .cmd_nack(cmd_nack),
        .status_evt(status_evt), .smbalert_req(smbalert_req),
        .output_enable(output_enable), .softstart_go(softstart_go),
        .nvm_wr(nvm_wr), .nvm_wr_data(nvm_wr_data));

    // -----------------------------------------------------------
    // Clock, timeout and shared tasks
    // -----------------------------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    // Hang guard, well above the run length
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 3000) begin
            fails++;
            conclude();
        end
    end

    task automatic conclude;
        if (fails == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [7:0] exp,
                       input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %s exp %h got %h", nm, exp, got);
        end
    endtask

    // Step n edges, land just after the last one
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    task automatic rd(input logic [7:0] c, input logic [7:0] e);
        host.xfer(1'b0, c, 8'h00);
        chk("read data", e, rd_data);
    endtask

    // One-cycle rise time pulses with a gap between
    task automatic rise(input int n);
        repeat (n) begin
            rise_done = 1'b1;
            cyc(1);
            rise_done = 1'b0;
            cyc(1);
        end
    endtask

    // -----------------------------------------------------------
    // Main sequence
    // -----------------------------------------------------------
    initial begin
        int k;
        {rst, loop_slave, ov_fault, uv_fault} = 4'h8;
        {fault_clear, output_off, rise_done} = 3'h0;
        {alert_masked, nvm_load, nvm_rd_bits, nvm_rd_en} = 6'h00;
        {fails, n_checks, cycles} = '0;
        cyc(4);
        rst = 1'b0;
        rd(UV, `VFR_RESP_RESET);
        rd(OV, `VFR_RESP_RESET);
        // Ignore mode on undervoltage, then a refused write
        host.xfer(1'b1, UV, 8'h38);
        rd(UV, 8'h3F);
        host.xfer(1'b1, UV, 8'hD0);
        chk("bad retry", 8'h07, {5'h0, status_evt.cml, status_evt.ivd,
            smbalert_req});
        rd(UV, 8'h3F);
        uv_fault = 1'b1;
        cyc(1);
        chk("uv events", 8'h68, status_evt);
        chk("uv alert", 8'h01, {7'h0, smbalert_req});
        cyc(3);
        chk("ignore enable", 8'h01, {7'h0, output_enable});
        uv_fault = 1'b0;
        alert_masked = 1'b1;
        cyc(1);
        uv_fault = 1'b1;
        cyc(1);
        chk("masked events", 8'h68, status_evt);
        chk("masked alert", 8'h00, {7'h0, smbalert_req});
        {alert_masked, uv_fault} = 2'h0;
        // Default overvoltage: shut down, delayed endless restart
        ov_fault = 1'b1;
        cyc(1);
        chk("ov events", 8'hB0, status_evt);
        chk("ov shutdown", 8'h00, {7'h0, output_enable});
        rise(6);
        chk("early go", 8'h00, {6'h0, softstart_go, output_enable});
        rise(1);
        for (k = 0; k < 8 && softstart_go !== 1'b1; k++) cyc(1);
        chk("restart go", 8'h01, {7'h0, softstart_go});
        cyc(2);
        chk("restarted", 8'h01, {7'h0, output_enable});
        // Commanded off while waiting: no restart until cleared
        ov_fault = 1'b0;
        cyc(1);
        {ov_fault, output_off} = 2'h3;
        cyc(1);
        rise(8);
        chk("off no go", 8'h00, {6'h0, softstart_go, output_enable});
        {output_off, fault_clear} = 2'h1;
        cyc(1);
        fault_clear = 1'b0;
        cyc(2);
        chk("off cleared", 8'h01, {7'h0, output_enable});
        ov_fault = 1'b0;
        // No-retry policy; bit 6 and delay bits are read-only
        host.xfer(1'b1, OV, 8'hC7);
        rd(OV, 8'h80);
        ov_fault = 1'b1;
        cyc(1);
        rise(9);
        chk("latched off", 8'h00, {7'h0, output_enable});
        {ov_fault, fault_clear} = 2'h1;
        cyc(1);
        fault_clear = 1'b0;
        cyc(2);
        chk("cleared", 8'h01, {7'h0, output_enable});
        // Store image {ov en, ov bit5, uv en, uv bit5}, then load
        host.xfer(1'b1, `VFR_CMD_STORE_ALL, 8'h00);
        chk("store", 8'h19, {3'h0, nvm_wr, nvm_wr_data});
        // Load ov en 0, ov bit5 1, uv en 1, uv bit5 0
        {nvm_rd_en, nvm_rd_bits, nvm_load} = 5'h0D;
        cyc(1);
        nvm_load = 1'b0;
        rd(OV, 8'h3F);
        rd(UV, 8'h80);
        ov_fault = 1'b1;
        cyc(2);
        chk("ov ignored", 8'h01, {7'h0, output_enable});
        ov_fault = 1'b0;
        // Undervoltage shuts down on its own setting, latched off
        uv_fault = 1'b1;
        cyc(1);
        chk("uv shutdown", 8'h00, {7'h0, output_enable});
        {uv_fault, fault_clear} = 2'h1;
        cyc(1);
        fault_clear = 1'b0;
        cyc(2);
        chk("uv cleared", 8'h01, {7'h0, output_enable});
        // Loop slave: access refused, setting untouched
        loop_slave = 1'b1;
        host.xfer(1'b1, UV, 8'hBF);
        chk("slave wr", 8'h03, {6'h0, cmd_nack, status_evt.invalid_command_fault});
        host.xfer(1'b0, UV, 8'h00);
        chk("slave rd", 8'h03, {6'h0, cmd_nack, status_evt.invalid_command_fault});
        loop_slave = 1'b0;
        rd(UV, 8'h80);
        cyc(2);
        conclude();
    end
endmodule
